// file: src/pam_port_mux.sv
`timescale 1ns/10ps
`include "pam_defs.svh"
// Notes on behaviour
// - Bus interface enable turns port 6 into the host data bus.
// - Frame pulse enable drives the low start-of-frame pulse on port 7 bit 0.
// - Port 7 bit 1 is the low bus request in expansion modes with hold.
// - Channel select enable takes port 7 bit 2 as low host select.
// - Input full and channel enables drive low input-full flag on 7.3.
// - Otherwise hold handshake in expansion modes drives low grant ack on 7.3.
// - Output full and channel enables drive output-full flag on port 7 bit 4.
// - Second UART transmit mode drives its TX on port 8 bit 0 first.
// - Else serial ctrl1 bit 4 gives low ready out, or input in slave mode.
// - Second UART receive mode takes its RX from port 8 bit 1 first.
// - Else ctrl1 bit 2 carries serial clock; bit 6 picks out or in.
// - Second UART control bit 5 makes port 8 bit 2 its low CTS input.
// - Else serial ctrl2 bit 2 takes serial data input from port 8 bit 2.
// - UART2 bit 6 drives low RTS on 8.3, else ctrl1 bit 3 serial out.
// - First UART TX goes out on 8.4 and RX comes from 8.5 when active.
// - First UART control bit 5 gives CTS on 8.6, bit 6 RTS on 8.7.
// - Boot pin at reset picks mode; mode bit 1 locked while pin high.
// - Transfer active output is high during DMA in expansion modes.
// - System clock is output in expansion modes, frozen high on stop or wait.
// - Opcode fetch marker is high one half output clock per fetch.
// - Read and store strobes go low on reads and writes in expansion modes.
// - Port 2 pull-up acts only where its bit is set and pin is input.
// - An enabled peripheral function decides pin direction over the register.
module pam_port_mux (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        boot_mode_pin,
  input  wire logic [7:0]  p2_in,
  output logic      [7:0]  p2_out,
  output logic      [7:0]  p2_oe,
  output logic      [7:0]  p2_pullup,
  input  wire logic [7:0]  p6_in,
  output logic      [7:0]  p6_out,
  output logic      [7:0]  p6_oe,
  input  wire logic [4:0]  p7_in,
  output logic      [4:0]  p7_out,
  output logic      [4:0]  p7_oe,
  input  wire logic [7:0]  p8_in,
  output logic      [7:0]  p8_out,
  output logic      [7:0]  p8_oe,
  input  wire logic [7:0]  hif_data_out,
  input  wire logic [7:0]  hif_data_oe,
  output logic      [7:0]  hif_data_in,
  input  wire logic        frame_pulse_n,
  output logic             bus_grant_request_n,
  input  wire logic        bus_grant_ack_n,
  output logic             host_select_ch1_n,
  input  wire logic        input_full_flag_ch1_n,
  input  wire logic        output_full_flag_ch1,
  input  wire logic        uart2_tx_mode,
  input  wire logic        uart2_txd,
  input  wire logic        uart2_rx_mode,
  output logic             uart2_rxd,
  output logic             uart2_cts_n,
  input  wire logic        uart2_rts_n,
  input  wire logic        sio_slave_mode,
  input  wire logic        sync_serial_ready_n,
  output logic             sync_serial_ready_in,
  input  wire logic        sync_serial_clock_out,
  output logic             sync_serial_clock_in,
  output logic             sync_serial_in,
  input  wire logic        sync_serial_out,
  input  wire logic        uart1_tx_mode,
  input  wire logic        uart1_txd,
  input  wire logic        uart1_rx_mode,
  output logic             uart1_rxd,
  output logic             uart1_cts_n,
  input  wire logic        uart1_rts_n,
  input  wire logic        dma_active,
  input  wire logic        cpu_halted,
  input  wire logic        opcode_fetch,
  input  wire logic        cpu_read,
  input  wire logic        cpu_write,
  output logic             transfer_active_out,
  output logic             system_clock_out,
  output logic             opcode_fetch_marker,
  output logic             read_strobe_n,
  output logic             store_strobe_n,
  output logic      [1:0]  processor_mode
);

  // Register file
  logic [7:0] p2_latch, p2_dir, p2_pull, p6_latch, p6_dir;
  logic [4:0] p7_latch, p7_dir;
  logic [7:0] p8_latch, p8_dir, func_en;
  logic [7:0] serial_port_ctrl1, serial_port_ctrl2;
  logic [7:0] uart1_ctrl, uart2_ctrl;
  logic [1:0] processor_mode_reg_a;

  // Synchroniser chains and filtered pin levels
  logic [29:0] pin_raw, sync1, sync2, sync3, filt;
  logic [7:0]  f_p2, f_p6, f_p8;
  logic [4:0]  f_p7;
  logic        f_boot;

  // Strap capture
  pam_pkg::pam_strap_type strap_state;
  logic [2:0]             strap_cnt;

  // Combinational pin selections
  logic [7:0] next_p6_out, next_p6_oe, next_p8_out, next_p8_oe;
  logic [4:0] next_p7_out, next_p7_oe;
  logic [31:0] next_rd;
  logic       expand, hold_on, sel_ch1, ibf_on, wr_en;

  assign pin_raw = {boot_mode_pin, p8_in, p7_in, p6_in, p2_in};
  assign {f_boot, f_p8, f_p7, f_p6, f_p2} = filt;
  assign expand  = processor_mode_reg_a != `PAM_MODE_SINGLE;
  assign hold_on = expand && func_en[`PAM_FE_HOLD];
  assign sel_ch1 = func_en[`PAM_FE_CH1_SEL];
  assign ibf_on  = sel_ch1 && func_en[`PAM_FE_INPUT_FULL_FLAG_CH1];
  assign wr_en   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
                   && wb_sel_i[0];

  // Three-stage synchroniser; a level counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 30; gi = gi + 1) begin : g_sync
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          sync1[gi] <= 1'h0;
          sync2[gi] <= 1'h0;
          sync3[gi] <= 1'h0;
          filt[gi]  <= 1'h0;
        end else begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            filt[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate

  // Wishbone handshake: one wait state, ack dropped the cycle after
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'h0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= next_rd;
    end
  end

  // Read mux; a port read shows the pin for inputs, the latch for outputs
  always_comb begin
    next_rd = 32'h0;
    case (wb_adr_i)
      `PAM_ADR_P2_DATA: next_rd[7:0] = (f_p2 & ~p2_dir) | (p2_latch & p2_dir);
      `PAM_ADR_P2_DIR:  next_rd[7:0] = p2_dir;
      `PAM_ADR_P2_PULL: next_rd[7:0] = p2_pull;
      `PAM_ADR_P6_DATA: next_rd[7:0] = (f_p6 & ~p6_dir) | (p6_latch & p6_dir);
      `PAM_ADR_P6_DIR:  next_rd[7:0] = p6_dir;
      `PAM_ADR_P7_DATA: next_rd[4:0] = (f_p7 & ~p7_dir) | (p7_latch & p7_dir);
      `PAM_ADR_P7_DIR:  next_rd[4:0] = p7_dir;
      `PAM_ADR_P8_DATA: next_rd[7:0] = (f_p8 & ~p8_dir) | (p8_latch & p8_dir);
      `PAM_ADR_P8_DIR:  next_rd[7:0] = p8_dir;
      `PAM_ADR_FUNC_EN: next_rd[7:0] = func_en;
      `PAM_ADR_SIO1:    next_rd[7:0] = serial_port_ctrl1;
      `PAM_ADR_SIO2:    next_rd[7:0] = serial_port_ctrl2;
      `PAM_ADR_UART1:   next_rd[7:0] = uart1_ctrl;
      `PAM_ADR_UART2:   next_rd[7:0] = uart2_ctrl;
      `PAM_ADR_MODE:    next_rd[1:0] = processor_mode_reg_a;
      default:          next_rd = 32'h0;
    endcase
  end

  // Port latches, directions and pull-up bits; reset leaves all inputs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      p2_latch <= `PAM_BYTE_RESET;
      p2_dir   <= `PAM_BYTE_RESET;
      p2_pull  <= `PAM_BYTE_RESET;
      p6_latch <= `PAM_BYTE_RESET;
      p6_dir   <= `PAM_BYTE_RESET;
      p7_latch <= 5'h0;
      p7_dir   <= 5'h0;
      p8_latch <= `PAM_BYTE_RESET;
      p8_dir   <= `PAM_BYTE_RESET;
    end else if (wr_en) begin
      case (wb_adr_i)
        `PAM_ADR_P2_DATA: p2_latch <= wb_dat_i[7:0];
        `PAM_ADR_P2_DIR:  p2_dir   <= wb_dat_i[7:0];
        `PAM_ADR_P2_PULL: p2_pull  <= wb_dat_i[7:0];
        `PAM_ADR_P6_DATA: p6_latch <= wb_dat_i[7:0];
        `PAM_ADR_P6_DIR:  p6_dir   <= wb_dat_i[7:0];
        `PAM_ADR_P7_DATA: p7_latch <= wb_dat_i[4:0];
        `PAM_ADR_P7_DIR:  p7_dir   <= wb_dat_i[4:0];
        `PAM_ADR_P8_DATA: p8_latch <= wb_dat_i[7:0];
        `PAM_ADR_P8_DIR:  p8_dir   <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // Peripheral enable and control registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      func_en           <= `PAM_BYTE_RESET;
      serial_port_ctrl1 <= `PAM_BYTE_RESET;
      serial_port_ctrl2 <= `PAM_BYTE_RESET;
      uart1_ctrl        <= `PAM_BYTE_RESET;
      uart2_ctrl        <= `PAM_BYTE_RESET;
    end else if (wr_en) begin
      case (wb_adr_i)
        `PAM_ADR_FUNC_EN: func_en           <= wb_dat_i[7:0];
        `PAM_ADR_SIO1:    serial_port_ctrl1 <= wb_dat_i[7:0];
        `PAM_ADR_SIO2:    serial_port_ctrl2 <= wb_dat_i[7:0];
        `PAM_ADR_UART1:   uart1_ctrl        <= wb_dat_i[7:0];
        `PAM_ADR_UART2:   uart2_ctrl        <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // Mode strap: the pin is read only after the synchroniser has settled,
  // since an asynchronous reset may not load a pin level
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      strap_state          <= pam_pkg::pam_strap_wait;
      strap_cnt            <= 3'h0;
      processor_mode_reg_a <= `PAM_MODE_SINGLE;
    end else begin
      case (strap_state)
        pam_pkg::pam_strap_wait: begin
          strap_cnt <= strap_cnt + 3'h1;
          if (strap_cnt == `PAM_STRAP_WAIT) begin
            strap_state          <= pam_pkg::pam_strap_done;
            processor_mode_reg_a <= f_boot ? `PAM_MODE_MICRO
                                           : `PAM_MODE_SINGLE;
          end
        end
        pam_pkg::pam_strap_done: begin
          if (wr_en && wb_adr_i == `PAM_ADR_MODE) begin
            processor_mode_reg_a[0] <= wb_dat_i[0];
            if (!f_boot) begin
              processor_mode_reg_a[`PAM_MODE_LOCK] <=
                wb_dat_i[`PAM_MODE_LOCK];
            end
          end
        end
        default: strap_state <= pam_pkg::pam_strap_wait;
      endcase
    end
  end

  // Pin function selection; an enabled peripheral owns the drive direction
  always_comb begin
    next_p6_out = p6_latch;
    next_p6_oe  = p6_dir;
    next_p7_out = p7_latch;
    next_p7_oe  = p7_dir;
    next_p8_out = p8_latch;
    next_p8_oe  = p8_dir;
    if (func_en[`PAM_FE_BUS_DATA]) begin
      next_p6_out = hif_data_out;
      next_p6_oe  = hif_data_oe;
    end
    if (func_en[`PAM_FE_FRAME]) begin
      next_p7_out[0] = frame_pulse_n;
      next_p7_oe[0]  = 1'h1;
    end
    if (hold_on) begin
      next_p7_oe[1] = 1'h0;
    end
    if (sel_ch1) begin
      next_p7_oe[2] = 1'h0;
    end
    if (ibf_on) begin
      next_p7_out[3] = input_full_flag_ch1_n;
      next_p7_oe[3]  = 1'h1;
    end else if (hold_on) begin
      next_p7_out[3] = bus_grant_ack_n;
      next_p7_oe[3]  = 1'h1;
    end
    if (sel_ch1 && func_en[`PAM_FE_OUTPUT_FULL_FLAG_CH1]) begin
      next_p7_out[4] = output_full_flag_ch1;
      next_p7_oe[4]  = 1'h1;
    end
    // Second UART outranks the clocked serial port on bits 0 to 3
    if (uart2_tx_mode) begin
      next_p8_out[0] = uart2_txd;
      next_p8_oe[0]  = 1'h1;
    end else if (serial_port_ctrl1[`PAM_SC1_RDY_EN]) begin
      next_p8_out[0] = sync_serial_ready_n;
      next_p8_oe[0]  = !sio_slave_mode;
    end
    if (uart2_rx_mode) begin
      next_p8_oe[1] = 1'h0;
    end else if (serial_port_ctrl1[`PAM_SC1_CLK_EN]) begin
      next_p8_out[1] = sync_serial_clock_out;
      next_p8_oe[1]  = serial_port_ctrl1[`PAM_SC1_CLK_OUT];
    end
    if (uart2_ctrl[`PAM_UC_CTS_EN]) begin
      next_p8_oe[2] = 1'h0;
    end else if (serial_port_ctrl2[`PAM_SC2_RXD_EN]) begin
      next_p8_oe[2] = 1'h0;
    end
    if (uart2_ctrl[`PAM_UC_RTS_EN]) begin
      next_p8_out[3] = uart2_rts_n;
      next_p8_oe[3]  = 1'h1;
    end else if (serial_port_ctrl1[`PAM_SC1_TXD_EN]) begin
      next_p8_out[3] = sync_serial_out;
      next_p8_oe[3]  = 1'h1;
    end
    if (uart1_tx_mode) begin
      next_p8_out[4] = uart1_txd;
      next_p8_oe[4]  = 1'h1;
    end
    if (uart1_rx_mode) begin
      next_p8_oe[5] = 1'h0;
    end
    if (uart1_ctrl[`PAM_UC_CTS_EN]) begin
      next_p8_oe[6] = 1'h0;
    end
    if (uart1_ctrl[`PAM_UC_RTS_EN]) begin
      next_p8_out[7] = uart1_rts_n;
      next_p8_oe[7]  = 1'h1;
    end
  end

  // Pin drivers, registered so every pin output comes from a flop
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      p2_out    <= `PAM_BYTE_RESET;
      p2_oe     <= `PAM_BYTE_RESET;
      p2_pullup <= `PAM_BYTE_RESET;
      p6_out    <= `PAM_BYTE_RESET;
      p6_oe     <= `PAM_BYTE_RESET;
      p7_out    <= 5'h0;
      p7_oe     <= 5'h0;
      p8_out    <= `PAM_BYTE_RESET;
      p8_oe     <= `PAM_BYTE_RESET;
    end else begin
      p2_out    <= p2_latch;
      p2_oe     <= p2_dir;
      p2_pullup <= p2_pull & ~p2_dir;
      p6_out    <= next_p6_out;
      p6_oe     <= next_p6_oe;
      p7_out    <= next_p7_out;
      p7_oe     <= next_p7_oe;
      p8_out    <= next_p8_out;
      p8_oe     <= next_p8_oe;
    end
  end

  // Inputs handed to peripherals; idle levels when the pin is not theirs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hif_data_in          <= `PAM_BYTE_RESET;
      bus_grant_request_n  <= 1'h1;
      host_select_ch1_n    <= 1'h1;
      uart2_rxd            <= 1'h1;
      uart2_cts_n          <= 1'h0;
      sync_serial_ready_in <= 1'h1;
      sync_serial_clock_in <= 1'h1;
      sync_serial_in       <= 1'h1;
      uart1_rxd            <= 1'h1;
      uart1_cts_n          <= 1'h0;
    end else begin
      hif_data_in         <= func_en[`PAM_FE_BUS_DATA] ? f_p6
                                                       : `PAM_BYTE_RESET;
      bus_grant_request_n <= hold_on ? f_p7[1] : 1'h1;
      host_select_ch1_n   <= sel_ch1 ? f_p7[2] : 1'h1;
      uart2_rxd           <= uart2_rx_mode ? f_p8[1] : 1'h1;
      uart2_cts_n         <= uart2_ctrl[`PAM_UC_CTS_EN] ? f_p8[2]
                                                        : 1'h0;
      sync_serial_ready_in <= (!uart2_tx_mode && sio_slave_mode
        && serial_port_ctrl1[`PAM_SC1_RDY_EN]) ? f_p8[0] : 1'h1;
      sync_serial_clock_in <= (!uart2_rx_mode
        && serial_port_ctrl1[`PAM_SC1_CLK_EN]
        && !serial_port_ctrl1[`PAM_SC1_CLK_OUT]) ? f_p8[1] : 1'h1;
      sync_serial_in <= (!uart2_ctrl[`PAM_UC_CTS_EN]
        && serial_port_ctrl2[`PAM_SC2_RXD_EN]) ? f_p8[2] : 1'h1;
      uart1_rxd   <= uart1_rx_mode ? f_p8[5] : 1'h1;
      uart1_cts_n <= uart1_ctrl[`PAM_UC_CTS_EN] ? f_p8[6] : 1'h0;
    end
  end

  // Expansion bus status; output clock is the system clock halved since
  // a flop cannot reproduce its own clock, so one half period is one cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      transfer_active_out <= 1'h0;
      system_clock_out    <= 1'h1;
      opcode_fetch_marker <= 1'h0;
      read_strobe_n       <= 1'h1;
      store_strobe_n      <= 1'h1;
      processor_mode      <= `PAM_MODE_SINGLE;
    end else begin
      transfer_active_out <= expand && dma_active;
      if (!expand || cpu_halted) begin
        system_clock_out <= 1'h1;
      end else begin
        system_clock_out <= !system_clock_out;
      end
      opcode_fetch_marker <= expand && opcode_fetch;
      read_strobe_n       <= !(expand && cpu_read);
      store_strobe_n      <= !(expand && cpu_write);
      processor_mode      <= processor_mode_reg_a;
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_bus_data_port: assert property (
    func_en[`PAM_FE_BUS_DATA] |=> p6_out == $past(hif_data_out)
      && p6_oe == $past(hif_data_oe))
    else $error("port 6 not following host data bus");
  chk_frame_pulse_pin: assert property (
    func_en[`PAM_FE_FRAME] |=> p7_oe[0] && p7_out[0] == $past(frame_pulse_n))
    else $error("frame pulse not on port 7 bit 0");
  chk_hold_request_idle: assert property (
    !hold_on |=> bus_grant_request_n)
    else $error("bus request active without hold handshake");
  chk_input_full_pin: assert property (
    ibf_on |=> p7_oe[3] && p7_out[3] == $past(input_full_flag_ch1_n))
    else $error("input full flag not on port 7 bit 3");
  chk_grant_ack_pin: assert property (
    (!ibf_on && hold_on) |=> p7_oe[3] && p7_out[3] == $past(bus_grant_ack_n))
    else $error("grant ack not on port 7 bit 3");
  chk_uart2_tx_pin: assert property (
    uart2_tx_mode |=> p8_oe[0] && p8_out[0] == $past(uart2_txd))
    else $error("second UART transmit not on port 8 bit 0");
  chk_serial_clock_dir: assert property (
    (!uart2_rx_mode && serial_port_ctrl1[`PAM_SC1_CLK_EN])
      |=> p8_oe[1] == $past(serial_port_ctrl1[`PAM_SC1_CLK_OUT]))
    else $error("serial clock direction wrong");
  chk_mode_lock_bit: assert property (
    (strap_state == pam_pkg::pam_strap_done && f_boot)
      |=> $stable(processor_mode_reg_a[`PAM_MODE_LOCK]))
    else $error("locked mode bit changed while boot pin high");
  chk_pullup_input_only: assert property (
    (p2_pullup & p2_oe) == 8'h0)
    else $error("pull-up on while port 2 pin drives");
  chk_clock_frozen_high: assert property (
    (cpu_halted || !expand) |=> system_clock_out)
    else $error("output clock not frozen high");
  chk_strobes_idle: assert property (
    !expand |=> read_strobe_n && store_strobe_n && !transfer_active_out)
    else $error("strobes active in single chip mode");
  chk_bus_ack_pulse: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle pulse");

  cov_strap_micro: cover property (
    strap_state == pam_pkg::pam_strap_done
      && processor_mode_reg_a == `PAM_MODE_MICRO);
  cov_uart2_tx_out: cover property (uart2_tx_mode ##1 p8_oe[0]);
  cov_grant_ack_out: cover property (!ibf_on && hold_on ##1 p7_oe[3]);
  cov_reg_write: cover property (wr_en);

endmodule

// file: src/pam_defs.svh
`ifndef PAM_DEFS_SVH
`define PAM_DEFS_SVH

// Register byte addresses on the bus
`define PAM_ADR_P2_DATA  8'h00
`define PAM_ADR_P2_DIR   8'h04
`define PAM_ADR_P2_PULL  8'h08
`define PAM_ADR_P6_DATA  8'h0C
`define PAM_ADR_P6_DIR   8'h10
`define PAM_ADR_P7_DATA  8'h14
`define PAM_ADR_P7_DIR   8'h18
`define PAM_ADR_P8_DATA  8'h1C
`define PAM_ADR_P8_DIR   8'h20
`define PAM_ADR_FUNC_EN  8'h24
`define PAM_ADR_SIO1     8'h28
`define PAM_ADR_SIO2     8'h2C
`define PAM_ADR_UART1    8'h30
`define PAM_ADR_UART2    8'h34
`define PAM_ADR_MODE     8'h38

// Function enable register bit positions
`define PAM_FE_BUS_DATA  0
`define PAM_FE_FRAME     1
`define PAM_FE_HOLD      2
`define PAM_FE_CH1_SEL   3
`define PAM_FE_INPUT_FULL_FLAG_CH1      4
`define PAM_FE_OUTPUT_FULL_FLAG_CH1      5

// Serial and UART control bit positions
`define PAM_SC1_CLK_EN   2
`define PAM_SC1_TXD_EN   3
`define PAM_SC1_RDY_EN   4
`define PAM_SC1_CLK_OUT  6
`define PAM_SC2_RXD_EN   2
`define PAM_UC_CTS_EN    5
`define PAM_UC_RTS_EN    6

// Processor mode codes and the write-protected bit
`define PAM_MODE_SINGLE  2'h0
`define PAM_MODE_MICRO   2'h2
`define PAM_MODE_LOCK    1

// Reset values and strap wait
`define PAM_BYTE_RESET   8'h00
`define PAM_STRAP_WAIT   3'h4

`endif

// file: src/pam_pkg.sv
package pam_pkg;

  // Boot strap capture sequence
  typedef enum logic { pam_strap_wait, pam_strap_done } pam_strap_type;

endpackage

// file: verification/pam_periph_model.sv
`timescale 1ns/10ps
// Stand-in for the UART, USB and host-bus cores; every line is drawn from an LFSR
// stepped each cycle, so a stale pin value seldom passes for a fresh one
module pam_periph_model (
  input  wire logic clock,
  input  wire logic rst_b,
  output logic      uart2_txd,
  output logic      uart1_txd,
  output logic      uart2_rts_n,
  output logic      uart1_rts_n,
  output logic      frame_pulse_n,
  output logic      grant_ack_n,
  output logic      in_full_n
);
  logic [7:0] pat;
  // Free-running pattern, restarted by reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pat <= 8'hA5;
    end else begin
      pat <= {pat[6:0], pat[7] ^ pat[5] ^ pat[4] ^ pat[3]};
    end
  end
  assign uart2_txd     = pat[0];
  assign uart1_txd     = pat[2];
  assign uart2_rts_n   = pat[1] ^ pat[0];
  assign uart1_rts_n   = pat[3] ^ pat[0];
  assign frame_pulse_n = pat[4] ^ pat[0];
  assign grant_ack_n   = pat[5] ^ pat[0];
  assign in_full_n     = pat[6] ^ pat[0];
endmodule

// file: verification/port_alternate_function_mux_tb.sv
`timescale 1ns/10ps
`include "pam_defs.svh"
module port_alternate_function_mux_tb;
  logic        clock, rst_b, cyc, stb, we, boot, ev, hlt, u2m, u1m, ack;
  logic        txd2, txd1, rts2, rts1, sof_n, ibf_n, ackn, req_n, sel_n;
  logic        sck, tao, rsn;
  logic        u1r, u2r, c1, c2, ofm, ssn, sync_serial_ready, ssin;
  logic [7:0]  p6o, p6e, hin;
  logic [7:0]  adr, rd, v, d, p8o, p8e, p2u, pin;
  logic [4:0]  p7i, p7o, p7e;
  logic [31:0] dw, dr;
  logic [1:0]  mode;
  int          n_fail, compares, i;

  pam_port_mux dut (
    .clock(clock), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_ack_o(ack), .boot_mode_pin(boot), .p2_in(pin),
    .p2_out(), .p2_oe(), .p2_pullup(p2u), .p6_in(pin), .p6_out(p6o),
    .p6_oe(p6e), .p7_in(p7i), .p7_out(p7o), .p7_oe(p7e), .p8_in(pin),
    .p8_out(p8o), .p8_oe(p8e), .hif_data_out(pin), .hif_data_oe(pin),
    .hif_data_in(hin), .frame_pulse_n(sof_n),
    .bus_grant_request_n(req_n),
    .bus_grant_ack_n(ackn), .host_select_ch1_n(sel_n),
    .input_full_flag_ch1_n(ibf_n), .output_full_flag_ch1(ev),
    .uart2_tx_mode(u2m), .uart2_txd(txd2), .uart2_rx_mode(u2m),
    .uart2_rxd(u2r), .uart2_cts_n(c2), .uart2_rts_n(rts2),
    .sio_slave_mode(ev), .sync_serial_ready_n(ev),
    .sync_serial_ready_in(sync_serial_ready), .sync_serial_clock_out(ev),
    .sync_serial_clock_in(), .sync_serial_in(ssin), .sync_serial_out(ev),
    .uart1_tx_mode(u1m), .uart1_txd(txd1), .uart1_rx_mode(u1m),
    .uart1_rxd(u1r), .uart1_cts_n(c1), .uart1_rts_n(rts1),
    .dma_active(ev),
    .cpu_halted(hlt), .opcode_fetch(ev), .cpu_read(ev), .cpu_write(ev),
    .transfer_active_out(tao), .system_clock_out(sck),
    .opcode_fetch_marker(ofm), .read_strobe_n(rsn),
    .store_strobe_n(ssn),
    .processor_mode(mode));
  pam_periph_model peer (.clock(clock), .rst_b(rst_b), .uart2_txd(txd2),
    .uart1_txd(txd1), .uart2_rts_n(rts2), .uart1_rts_n(rts1),
    .frame_pulse_n(sof_n), .grant_ack_n(ackn), .in_full_n(ibf_n));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic cycle: hold everything until ack is seen at a rising edge
  task automatic bus(logic w, logic [7:0] a, logic [7:0] dat);
    int j;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= {24'h0, dat};
    for (j = 0; j < 20; j++) begin
      @(posedge clock);
      if (ack === 1'b1) break;
    end
    if (j == 20) begin
      n_fail++;
      stop_test();
    end
    rd = dr[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    #1;
  endtask

  // Waits n edges, then lets their updates land
  task automatic wt(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  initial begin
    repeat (100000) @(posedge clock);
    n_fail++;
    stop_test();
  end

  initial begin
    {rst_b, cyc, stb, we, ev, hlt, u2m, u1m} = '0;
    {adr, dw, pin} = '0;
    boot = 1'b1;
    p7i = 5'h1F;
    void'($urandom(11156));
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    wt(12);
    // Reset values, boot strap and unmapped words
    for (i = 0; i <= 64; i += 4) begin
      bus(0, i[7:0], 8'h00);
      // Port 7 inputs read the pins, held high; mode shows the boot strap
      v = (i == 20) ? 8'h1F : (i == 56) ? 8'h02 : 8'h00;
      chk("reg", v, rd);
    end
    $display("Test reset finished");
    v = $urandom;
    d = $urandom;
    bus(1, `PAM_ADR_P8_DATA, v);
    bus(1, `PAM_ADR_P8_DIR, d);
    bus(1, `PAM_ADR_P2_PULL, v);
    bus(1, `PAM_ADR_P2_DIR, d);
    bus(0, `PAM_ADR_P8_DATA, 8'h00);
    chk("p8 read", v & d, rd);
    chk("p8 pins", {v, d}, {p8o, p8e});
    chk("pullup", v & ~d, p2u);
    $display("Test plain ports finished");
    bus(1, `PAM_ADR_UART2, 8'h60);
    bus(1, `PAM_ADR_UART1, 8'h60);
    bus(1, `PAM_ADR_FUNC_EN, 8'h02);
    u2m <= 1'b1;
    u1m <= 1'b1;
    pin <= 8'($urandom);
    // Pin inputs need the synchroniser and the output flop to settle
    wt(6);
    for (i = 0; i < 8; i++) begin
      @(posedge clock);
      v = {rts1, 2'b00, txd1, rts2, 2'b00, txd2};
      d = {7'h00, sof_n};
      #1;
      chk("p8 uart", {8'h99, v}, {p8e, p8o} & 16'h9999);
      chk("p7 frame", {1'b1, d[0]}, {p7e[0], p7o[0]});
    end
    chk("rxd", {pin[5], pin[1]}, {u1r, u2r});
    chk("cts", {pin[6], pin[2]}, {c1, c2});
    $display("Test uart pins finished");
    bus(1, `PAM_ADR_MODE, 8'h00);
    bus(0, `PAM_ADR_MODE, 8'h00);
    chk("mode lock", 2, rd);
    bus(1, `PAM_ADR_MODE, 8'h01);
    wt(2);
    chk("mode", 3, mode);
    v[0] = sck;
    wt(1);
    chk("clk out", !v[0], sck);
    hlt <= 1'b1;
    ev <= 1'b1;
    wt(3);
    chk("core", 5'h16, {sck, rsn, tao, ofm, ssn});
    wt(1);
    chk("clk stop", 1, sck);
    $display("Test expansion finished");
    bus(1, `PAM_ADR_FUNC_EN, 8'h04);
    p7i <= 5'h00;
    wt(8);
    @(posedge clock);
    d[0] = ackn;
    #1;
    chk("hold", {2'b01, d[0]}, {req_n, p7e[3], p7o[3]});
    bus(1, `PAM_ADR_FUNC_EN, 8'h3D);
    wt(3);
    @(posedge clock);
    d[0] = ibf_n;
    #1;
    v = {3'h0, sel_n, p7e[4:3], p7o[4:3]};
    chk("ch1", {6'h03, ev, d[0]}, v);
    chk("p6 bus", {pin, pin}, {p6o, p6e});
    chk("hif in", pin, hin);
    $display("Test host pins finished");
    // Second UART off: the clocked serial port takes port 8 bits 0 to 3
    bus(1, `PAM_ADR_UART2, 8'h00);
    bus(1, `PAM_ADR_SIO1, 8'h5C);
    bus(1, `PAM_ADR_SIO2, 8'h04);
    u2m <= 1'b0;
    wt(3);
    v = {p8e[3:0], p8o[3], p8o[1], ssin, sync_serial_ready};
    chk("sio", {4'hA, 2'h3, pin[2], pin[0]}, v);
    $display("Test serial pins finished");
    stop_test();
  end
endmodule
